/* File: ebrw_mem_model.sv */
// Purpose: external memory model that answers bus commands with the ready line
// Assumes: commands and ready are active low; runs on the link clock
// Notes:   data line shows an inverted value outside read commands
`timescale 1ns/100ps
`default_nettype none
module ebrw_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic [15:0] val_i,
  output logic             ready_n_o,
  output logic [15:0]      data_o
);
  logic [3:0] cnt_q;
  initial begin
    ready_n_o = 1'b1;
    data_o    = 16'h0000;
    cnt_q     = 4'h0;
  end
  always @(posedge clk_i) begin
    if (rd_n_i && wr_n_i) begin
      ready_n_o <= 1'b1;
      cnt_q     <= 4'h0;
      data_o    <= ~data_o;
    end else begin
      // low until the command ends, long enough for the synchroniser
      if (cnt_q >= dly_i) ready_n_o <= 1'b0;
      else cnt_q <= cnt_q + 4'h1;
      data_o <= rd_n_i ? ~data_o : val_i;
    end
  end
endmodule : ebrw_mem_model
`default_nettype wire

/* File: ebrw_pkg.sv */
// Purpose: types of the external bus ready/waitstate block
// Assumes: used through scoped names only
// Notes:   states of the bus cycle sequencer
package ebrw_pkg;
  typedef enum logic [2:0] {
    EBRW_IDLE  = 3'b000,
    EBRW_SETUP = 3'b001,
    EBRW_CMD   = 3'b010,
    EBRW_WAIT  = 3'b011,
    EBRW_RDYWS = 3'b100,
    EBRW_MUXWS = 3'b101,
    EBRW_TRIWS = 3'b110
  } ebrw_state_e;
endpackage : ebrw_pkg

/* File: ebrw_regs.svh */
// Purpose: register offsets, fields, reset values and timing counts of the external bus ready/waitstate block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef EBRW_REGS_SVH
`define EBRW_REGS_SVH

`define EBRW_CTRL_OFS        8'h00
`define EBRW_WINCFG_OFS      8'h04
`define EBRW_REQ_OFS         8'h08
`define EBRW_WDATA_OFS       8'h0C
`define EBRW_STATUS_OFS      8'h10
`define EBRW_RDATA_OFS       8'h14

// ctrl fields
`define EBRW_CTRL_MEM_WS_LSB 0
`define EBRW_CTRL_MEM_WS_W   4
`define EBRW_CTRL_RWDLY_BIT  4
`define EBRW_CTRL_MUX_BIT    5
`define EBRW_CTRL_TRI_BIT    6
`define EBRW_CTRL_RST        32'h0000_0000
// per-window fields: bit 2w = ready used, bit 2w+1 = async
`define EBRW_WINCFG_RST      32'h0000_0000
// request fields
`define EBRW_REQ_ADDR_W      16
`define EBRW_REQ_WR_BIT      16
`define EBRW_REQ_WIN_LSB     17
// status fields
`define EBRW_STAT_BUSY_BIT   0
`define EBRW_STAT_DONE_BIT   1
`define EBRW_STAT_READY_WS_LSB 8

// timing: the system clock output is the link clock itself
`define EBRW_CLK_PERIOD_NS   5
`define EBRW_GAP_MUXTRI_CYC  2

`endif

/* File: ebrw_sync.sv */
// Purpose: two-flop synchroniser for a level entering a clock domain
// Assumes: input is asynchronous to clk_i
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module ebrw_sync #(
  parameter int RST_VAL = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'(RST_VAL);
      sync_q <= 1'(RST_VAL);
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : ebrw_sync
`default_nettype wire

/* File: ebrw_top.sv */
// Purpose: external bus cycle sequencer with ready handshake and programmed waitstates
// Assumes: AXI4-Lite register access on clk_i; bus side runs on link_clk_i
// Notes:   one external cycle at a time, started by a write to the request register
`timescale 1ns/100ps
`default_nettype none
`include "ebrw_regs.svh"

// Overview of operation
// - ready line sampled high at sampling point adds one ready waitstate and resamples
// - ready line sampled low at sampling point ends the running bus cycle
// - every cycle runs its programmed length with memory waitstates before ready extension
// - command leading edge is delayed when read/write delay is enabled
// - multiplexed mode appends a gap waitstate, plus a tristate waitstate if configured
// - next-cycle gap is two clock-output cycles muxed with tristate, zero demuxed without
// - read data captured on the edge that raises read strobe; address holds until the next request
module ebrw_top #(
  parameter int NWIN = 4,
  parameter int AW   = 16,
  parameter int DW   = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          link_clk_i,
  input  wire logic          link_rst_i,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               system_clock_output_o,
  output logic [AW-1:0]      ext_addr_o,
  output logic               ext_ale_o,
  output logic               ext_rd_n_o,
  output logic               ext_wr_n_o,
  output logic [DW-1:0]      ext_data_o,
  output logic               ext_data_oe_o,
  input  wire logic [DW-1:0] ext_data_i,
  input  wire logic          ext_ready_n_i
);
  // ---------------- register side (clk_i) ----------------
  logic [31:0]      ctrl_q;
  logic [31:0]      wincfg_q;
  logic [31:0]      req_q;
  logic [DW-1:0]    wdata_q;
  logic [DW-1:0]    rdata_q;
  logic [7:0]       rdyws_q;
  logic             busy_q;
  logic             done_q;
  logic             start_tgl_q;
  logic             aw_hold_q;
  logic             w_hold_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdat_q;
  logic [3:0]       wstrb_q;
  logic             done_sync;
  logic             done_seen_q;
  logic             wr_fire;
  logic [31:0]      wmask;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;
  assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wmask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdat_q       <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdat_q   <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; a request write while busy is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= `EBRW_CTRL_RST;
      wincfg_q    <= `EBRW_WINCFG_RST;
      req_q       <= 32'h0000_0000;
      wdata_q     <= '0;
      start_tgl_q <= 1'b0;
    end else if (wr_fire) begin
      case (awaddr_q)
        `EBRW_CTRL_OFS:   ctrl_q   <= (ctrl_q & ~wmask) | (wdat_q & wmask);
        `EBRW_WINCFG_OFS: wincfg_q <= (wincfg_q & ~wmask) | (wdat_q & wmask);
        `EBRW_WDATA_OFS:  wdata_q  <= DW'((32'(wdata_q) & ~wmask) | (wdat_q & wmask));
        `EBRW_REQ_OFS: begin
          if (!busy_q) begin
            req_q       <= wdat_q;
            start_tgl_q <= ~start_tgl_q;
          end
        end
        default: ;
      endcase
    end
  end

  // busy/done tracking; completion is a toggle back from the link domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      done_seen_q <= 1'b0;
    end else begin
      done_seen_q <= done_sync;
      if (wr_fire && awaddr_q == `EBRW_REQ_OFS && !busy_q) begin
        busy_q <= 1'b1;
        done_q <= 1'b0;
      end else if (done_sync != done_seen_q) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `EBRW_CTRL_OFS:   s_axi_rdata <= ctrl_q;
        `EBRW_WINCFG_OFS: s_axi_rdata <= wincfg_q;
        `EBRW_REQ_OFS:    s_axi_rdata <= req_q;
        `EBRW_WDATA_OFS:  s_axi_rdata <= 32'(wdata_q);
        `EBRW_STATUS_OFS: s_axi_rdata <= {16'h0000, rdyws_q, 6'h00, done_q, busy_q};
        `EBRW_RDATA_OFS:  s_axi_rdata <= 32'(rdata_q);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ---------------- link side (link_clk_i) ----------------
  // the request word is held while busy, so it crosses with the start toggle; ctrl and window config are not held;
  // changing ctrl or window config while a cycle runs is not supported
  localparam int WINW = (NWIN > 1) ? $clog2(NWIN) : 1;

  ebrw_pkg::ebrw_state_e state_q;
  ebrw_pkg::ebrw_state_e state_d;
  logic                  start_sync;
  logic                  start_seen_q;
  logic                  start_pend;
  logic                  done_tgl_q;
  logic                  rdy_sync;
  logic                  rdy_late_q;
  logic                  rdy_n_sel;
  logic [DW-1:0]         data_sync;
  logic [4:0]            cnt_q;
  logic [4:0]            last_cnt;
  logic                  wr_q;
  logic                  rwdly_q;
  logic                  mux_q;
  logic                  tri_q;
  logic                  rdy_used_q;
  logic                  async_q;
  logic [3:0]            memws_q;
  logic [WINW-1:0]       req_win;
  logic                  cmd_last;
  logic                  sample_pt;
  logic                  ready_wait;
  logic                  cycle_end;
  logic                  cmd_on;

  // the link clock is presented at the pin
  assign system_clock_output_o = link_clk_i;
  assign start_pend = start_sync != start_seen_q;
  assign req_win    = req_q[`EBRW_REQ_WIN_LSB +: WINW];
  assign last_cnt   = {1'b0, memws_q} + 5'h01;
  assign cmd_last   = (state_q == ebrw_pkg::EBRW_CMD) && (cnt_q == last_cnt);
  assign sample_pt  = cmd_last || (state_q == ebrw_pkg::EBRW_RDYWS);
  assign rdy_n_sel  = async_q ? rdy_late_q : rdy_sync;
  assign ready_wait = rdy_used_q && rdy_n_sel;
  assign cycle_end  = sample_pt && !ready_wait;
  // with read/write delay the command stays off in the first command cycle
  assign cmd_on     = ((state_q == ebrw_pkg::EBRW_CMD) && !(rwdly_q && cnt_q == 5'h00)) ||
                      (state_q == ebrw_pkg::EBRW_RDYWS);
  assign ext_rd_n_o    = !(cmd_on && !wr_q);
  assign ext_wr_n_o    = !(cmd_on && wr_q);
  assign ext_ale_o     = state_q == ebrw_pkg::EBRW_SETUP;
  assign ext_data_oe_o = wr_q && ((state_q == ebrw_pkg::EBRW_SETUP) || (state_q == ebrw_pkg::EBRW_CMD) ||
                                  (state_q == ebrw_pkg::EBRW_RDYWS));

  ebrw_sync #(
    .RST_VAL(0)
  ) i_start_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_i),
    .d_i   (start_tgl_q),
    .q_o   (start_sync)
  );

  ebrw_sync #(
    .RST_VAL(0)
  ) i_done_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (done_tgl_q),
    .q_o   (done_sync)
  );

  ebrw_sync #(
    .RST_VAL(1)
  ) i_rdy_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_i),
    .d_i   (ext_ready_n_i),
    .q_o   (rdy_sync)
  );

  for (genvar gi = 0; gi < DW; gi++) begin : g_data_sync
    ebrw_sync #(
      .RST_VAL(0)
    ) i_bit (
      .clk_i (link_clk_i),
      .rst_i (link_rst_i),
      .d_i   (ext_data_i[gi]),
      .q_o   (data_sync[gi])
    );
  end

  // asynchronous ready takes one more stage than synchronous ready
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      rdy_late_q   <= 1'b1;
      start_seen_q <= 1'b0;
    end else begin
      rdy_late_q   <= rdy_sync;
      start_seen_q <= start_sync;
    end
  end

  // per-cycle settings are taken when the start toggle arrives
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      wr_q       <= 1'b0;
      rwdly_q    <= 1'b0;
      mux_q      <= 1'b0;
      tri_q      <= 1'b0;
      memws_q    <= 4'h0;
      rdy_used_q <= 1'b0;
      async_q    <= 1'b0;
      ext_addr_o <= '0;
      ext_data_o <= '0;
    end else if (state_q == ebrw_pkg::EBRW_IDLE && start_pend) begin
      wr_q       <= req_q[`EBRW_REQ_WR_BIT];
      rwdly_q    <= ctrl_q[`EBRW_CTRL_RWDLY_BIT];
      mux_q      <= ctrl_q[`EBRW_CTRL_MUX_BIT];
      tri_q      <= ctrl_q[`EBRW_CTRL_TRI_BIT];
      memws_q    <= ctrl_q[`EBRW_CTRL_MEM_WS_LSB +: `EBRW_CTRL_MEM_WS_W];
      rdy_used_q <= wincfg_q[2 * req_win];
      async_q    <= wincfg_q[2 * req_win + 1];
      ext_addr_o <= req_q[AW-1:0];
      ext_data_o <= wdata_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ebrw_pkg::EBRW_IDLE: begin
        if (start_pend) state_d = ebrw_pkg::EBRW_SETUP;
      end
      ebrw_pkg::EBRW_SETUP: begin
        state_d = ebrw_pkg::EBRW_CMD;
      end
      ebrw_pkg::EBRW_CMD, ebrw_pkg::EBRW_RDYWS: begin
        if (cycle_end) state_d = mux_q ? ebrw_pkg::EBRW_MUXWS : ebrw_pkg::EBRW_IDLE;
        else if (sample_pt) state_d = ebrw_pkg::EBRW_RDYWS;
      end
      ebrw_pkg::EBRW_MUXWS: begin
        state_d = tri_q ? ebrw_pkg::EBRW_TRIWS : ebrw_pkg::EBRW_IDLE;
      end
      ebrw_pkg::EBRW_TRIWS: begin
        state_d = ebrw_pkg::EBRW_IDLE;
      end
      default: begin
        state_d = ebrw_pkg::EBRW_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      state_q <= ebrw_pkg::EBRW_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // programmed length runs out before ready is looked at
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      cnt_q <= 5'h00;
    end else if (state_q == ebrw_pkg::EBRW_CMD && !cmd_last) begin
      cnt_q <= cnt_q + 5'h01;
    end else if (state_q != ebrw_pkg::EBRW_CMD) begin
      cnt_q <= 5'h00;
    end
  end

  // results are stable before the done toggle reaches the register side
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      done_tgl_q <= 1'b0;
      rdata_q    <= '0;
      rdyws_q    <= 8'h00;
    end else begin
      if (state_q != ebrw_pkg::EBRW_IDLE && state_d == ebrw_pkg::EBRW_IDLE) done_tgl_q <= ~done_tgl_q;
      if (cycle_end && !wr_q) rdata_q <= data_sync;
      if (state_q == ebrw_pkg::EBRW_IDLE && start_pend) begin
        rdyws_q <= 8'h00;
      end else if (state_d == ebrw_pkg::EBRW_RDYWS && rdyws_q != 8'hff) begin
        rdyws_q <= rdyws_q + 8'h01;
      end
    end
  end

  chk_ready_adds_wait : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (sample_pt && ready_wait) |=> (state_q == ebrw_pkg::EBRW_RDYWS && (!ext_rd_n_o || !ext_wr_n_o)))
    else $error("ready high did not add a waitstate");

  chk_ready_ends_cycle : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    cycle_end |=> (ext_rd_n_o && ext_wr_n_o))
    else $error("command still active after cycle end");

  chk_prog_length : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (state_q == ebrw_pkg::EBRW_CMD && cnt_q < last_cnt) |=> (state_q == ebrw_pkg::EBRW_CMD))
    else $error("cycle ended before its programmed length");

  chk_cmd_delay : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (state_q == ebrw_pkg::EBRW_SETUP) |=> ((ext_rd_n_o && ext_wr_n_o) == rwdly_q))
    else $error("command leading edge does not follow the delay setting");

  chk_mux_gap : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (cycle_end && mux_q) |=> (state_q == ebrw_pkg::EBRW_MUXWS))
    else $error("multiplexed cycle without gap waitstate");

  chk_gap_two : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (cycle_end && mux_q && tri_q) |=> (state_q == ebrw_pkg::EBRW_MUXWS) ##1 (state_q == ebrw_pkg::EBRW_TRIWS)
      ##1 (state_q == ebrw_pkg::EBRW_IDLE))
    else $error("muxed gap with tristate waitstate is not two cycles");

  chk_gap_zero : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (cycle_end && !mux_q) |=> (state_q == ebrw_pkg::EBRW_IDLE))
    else $error("demultiplexed cycle left a gap");

  chk_rdata_capture : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (cycle_end && !wr_q) |=> (rdata_q == $past(data_sync)))
    else $error("read data not taken at the strobe's trailing edge");

  chk_window_bypass : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    (cmd_last && !rdy_used_q) |=> (state_q != ebrw_pkg::EBRW_RDYWS))
    else $error("ready waitstate in a window without ready");
endmodule : ebrw_top
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench of the external bus ready/waitstate block
// Assumes: registers over AXI4-Lite, memory model on the bus side
// Notes:   command lengths are counted in link clock cycles
`timescale 1ns/100ps
`default_nettype none
`include "ebrw_regs.svh"
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, link_clk_i = 1'b0, link_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf, mdly = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic system_clock_output_o, ext_ale_o, ext_rd_n_o, ext_wr_n_o, ext_data_oe_o, ext_ready_n_i;
  logic [15:0] ext_addr_o, ext_data_o, ext_data_i, wr_seen, addr_seen;
  int failures = 0, checked = 0, cmd_len = 0, l0, l1, l2;
  ebrw_top i_dut (.clk_i, .rst_i, .link_clk_i, .link_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .system_clock_output_o, .ext_addr_o, .ext_ale_o, .ext_rd_n_o, .ext_wr_n_o, .ext_data_o, .ext_data_oe_o,
    .ext_data_i, .ext_ready_n_i);
  ebrw_mem_model i_mem (.clk_i(link_clk_i), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .dly_i(mdly),
    .val_i(16'h5a3c), .ready_n_o(ext_ready_n_i), .data_o(ext_data_i));
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  always @(posedge link_clk_i) begin
    if (!ext_rd_n_o || !ext_wr_n_o) cmd_len <= cmd_len + 1;
    if (!ext_wr_n_o) wr_seen <= ext_data_oe_o ? ext_data_o : 16'h0000;
    if (ext_ale_o) addr_seen <= ext_addr_o;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic test_done();
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axr
  // one external cycle on window 0; returns the command length
  task automatic xfer(input logic [31:0] ctl, input logic [31:0] win, input logic wr, input logic [3:0] d,
                      output int len);
    int n;
    n = 0;
    mdly <= d;
    axw(`EBRW_CTRL_OFS, ctl);
    axw(`EBRW_WINCFG_OFS, win);
    axw(`EBRW_WDATA_OFS, 32'h0000_c3a5);
    cmd_len = 0;
    axw(`EBRW_REQ_OFS, {15'h0000, wr, 16'h1234});
    repeat (40) @(posedge clk_i);
    do begin
      axr(`EBRW_STATUS_OFS, rv);
      n++;
    end while (rv[`EBRW_STAT_BUSY_BIT] !== 1'b0 && n < 200);
    cmp({30'h0, rv[1:0]}, 32'h0000_0002);
    cmp({16'h0000, addr_seen}, 32'h0000_1234);
    len = cmd_len;
  endtask : xfer
  task automatic t_regs();
    axr(`EBRW_CTRL_OFS, rv);
    cmp(rv, `EBRW_CTRL_RST);
    axr(`EBRW_WINCFG_OFS, rv);
    cmp(rv, `EBRW_WINCFG_RST);
    axw(8'h3c, 32'h0000_00ff);
    axr(8'h3c, rv);
    cmp(rv, 32'h0000_0000);
  endtask : t_regs
  task automatic t_ready();
    xfer(32'h0, 32'h1, 1'b0, 4'h0, l0);
    axr(`EBRW_RDATA_OFS, rv);
    cmp(rv, 32'h0000_5a3c);
    xfer(32'h0, 32'h1, 1'b0, 4'h3, l1);
    cmp(l1 - l0 >= 3, 1);
    cmp(rv[15:8] != 8'h00, 1);
    xfer(32'h0, 32'h3, 1'b0, 4'h3, l2);
    cmp(l2 > l1, 1);
  endtask : t_ready
  task automatic t_waits();
    xfer(32'h0, 32'h0, 1'b0, 4'h0, l0);
    xfer(32'h2, 32'h0, 1'b0, 4'h0, l1);
    cmp(l1 - l0, 2);
    xfer(32'h10, 32'h0, 1'b0, 4'h0, l1);
    cmp(l1 < l0, 1);
    xfer(32'h0, 32'h1, 1'b1, 4'h1, l1);
    cmp({16'h0000, wr_seen}, 32'h0000_c3a5);
  endtask : t_waits
  task automatic t_window();
    xfer(32'h60, 32'h0, 1'b0, 4'hf, l1);
    cmp(l1 < 15, 1);
    cmp({24'h0, rv[15:8]}, 32'h0000_0000);
    axr(`EBRW_CTRL_OFS, rv);
    cmp(rv, 32'h0000_0060);
  endtask : t_window
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    link_rst_i <= 1'b0;
    t_regs();
    t_ready();
    t_waits();
    t_window();
    test_done();
  end
  initial begin
    #400000;
    failures++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
